// ### core/hundredth_tick.sv
// free running divider giving one pulse per hundredth of a second
`timescale 1ns/1ns
`default_nettype none
module hundredth_tick
  import step_seq_pkg::*;
#(
  parameter int unsigned DIVIDE = HUNDREDTH_CYCLES
)(
  input wire logic clk_sys_i, // system clock
  input wire logic rst_b_i, // async reset, active low
  output logic tick_o // one-cycle pulse
);

  logic [31:0] count;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count <= 32'h0000_0000;
      tick_o <= 1'b0;
    end
    else if (count >= 32'(DIVIDE - 1))
    begin
      count <= 32'h0000_0000;
      tick_o <= 1'b1;
    end
    else
    begin
      count <= count + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end

endmodule : hundredth_tick
`default_nettype wire

// ### core/step_seq_pkg.sv
// constants, register map and carrier types of the step sequencer
package step_seq_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned HUNDREDTH_NS = 10_000_000;
  localparam int unsigned HUNDREDTH_CYCLES = HUNDREDTH_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned STEP_NUM = 16;
  localparam int unsigned POOL_NUM = 128;
  localparam int unsigned SEQ_WORDS = 4;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_TIMEBASE = 12'h008;
  localparam logic [11:0] OFS_BASE_INDEX = 12'h00C;
  localparam logic [11:0] OFS_COUNTS = 12'h040;
  localparam logic [11:0] OFS_EVSEL = 12'h080;
  localparam logic [11:0] OFS_PATTERN = 12'h0C0;
  localparam logic [11:0] OFS_POOL = 12'h200;
  localparam logic [11:0] TABLE_SPAN = 12'h040;
  localparam logic [11:0] POOL_SPAN = 12'h200;

  // word positions inside the sequencer's four pool words
  localparam logic [6:0] WORD_STEP_COUNT = 7'h00;
  localparam logic [6:0] WORD_TICK_TIMER = 7'h01;
  localparam logic [6:0] WORD_PRESET = 7'h02;
  localparam logic [6:0] WORD_CURRENT = 7'h03;

  // ****************************************************************
  // reset values and bus response codes
  // ****************************************************************
  localparam logic [4:0] PRESET_RESET = 5'h01;
  localparam logic [15:0] TIMEBASE_RESET = 16'h0001;
  localparam logic [6:0] BASE_INDEX_RESET = 7'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic event_variant;
    logic non_retentive;
    logic reset;
    logic jog;
    logic start;
    logic run;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = 6'h00;

  typedef struct packed {
    logic enable;
    logic [3:0] point;
  } evsel_type;

  typedef enum logic [1:0] {
    ST_PROGRAM = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_COMPLETE = 2'h3
  } seq_state_type;

endpackage : step_seq_pkg

// ### core/step_sequencer.sv
// sixteen-step output sequencer with an AXI4-Lite register file
// Behaviour
// - final step done sets flag and complete in the same cycle
// - complete holds final pattern, ignores start, jog
// - reset or run entry clears flag; reset loads preset
// - start acts only while reset inactive
// - start off freezes step, count, timer, outputs, but jog still steps
// - event variant: jog rising edge advances step
// - reset beats start, forces preset step
// - held in preset while reset active
// - preset 1..16, entered on reset, non-retentive or post-complete run entry
// - each step has own count parameter
// - four words at base index among 128
// - one optional event point per step
// - outputs follow current step in run mode
// - non-retentive run entry clears, loads preset
// - retentive default keeps all four words unless flag set
// - current step stays final when complete
// - jog clears timer, timing restarts at once
// - jog in final step completes the sequence
// - step time is hundredths x timebase x counts
// - timer runs only while step event true
`timescale 1ns/1ns
`default_nettype none
module step_sequencer
  import step_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = HUNDREDTH_CYCLES
)(
  input wire logic clk_sys_i, // system clock, 20 MHz
  input wire logic rst_b_i, // async reset, active low
  input wire logic scan_i, // controller scan strobe
  input wire logic [15:0] event_points_i, // discrete event points
  output logic [15:0] pattern_o, // step output pattern
  output logic complete_o, // completion flag
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  // ****************************************************************
  // storage
  // ****************************************************************
  ctrl_type ctrl;
  logic [15:0] timebase;
  logic [6:0] base_index;
  logic [15:0] counts [STEP_NUM];
  evsel_type evsel [STEP_NUM];
  logic [15:0] pattern [STEP_NUM];
  logic [15:0] step_count_word;
  logic [15:0] tick_timer_word;
  logic [4:0] preset_step_word;
  logic [4:0] current_step_word;
  logic completion_flag;
  seq_state_type state;
  logic run_q;
  logic jog_q;
  logic [15:0] pending;
  logic tick;

  // ****************************************************************
  // write channel
  // ****************************************************************
  logic [11:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_go;
  logic wr_hit;
  logic [31:0] wr_word;
  logic [11:0] wr_rel;
  logic [6:0] wr_pool_off;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wr_word[8*b +: 8] = w_strb[b] ? w_data[8*b +: 8] : 8'h00;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write decode
  always_comb
  begin
    wr_rel = aw_addr - OFS_POOL;
    wr_pool_off = wr_rel[8:2] - base_index;
    wr_hit = 1'b0;
    if (aw_addr == OFS_CTRL || aw_addr == OFS_TIMEBASE || aw_addr == OFS_BASE_INDEX
        || aw_addr == OFS_STATUS)
    begin
      wr_hit = 1'b1;
    end
    else if ((aw_addr >= OFS_COUNTS && aw_addr < OFS_PATTERN + TABLE_SPAN)
             || (aw_addr >= OFS_POOL && aw_addr < OFS_POOL + POOL_SPAN))
    begin
      wr_hit = 1'b1;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl <= CTRL_RESET;
      timebase <= TIMEBASE_RESET;
      base_index <= BASE_INDEX_RESET;
      for (int s = 0; s < STEP_NUM; s++)
      begin
        counts[s] <= 16'h0000;
        evsel[s] <= 5'h00;
        pattern[s] <= 16'h0000;
      end
    end
    else if (wr_go)
    begin
      if (aw_addr == OFS_CTRL)
        ctrl <= wr_word[5:0];
      if (aw_addr == OFS_TIMEBASE)
        timebase <= wr_word[15:0];
      if (aw_addr == OFS_BASE_INDEX)
        base_index <= (wr_word[6:0] > 7'(POOL_NUM - SEQ_WORDS)) ?
                      7'(POOL_NUM - SEQ_WORDS) : wr_word[6:0];
      if (aw_addr[11:6] == OFS_COUNTS[11:6])
        counts[aw_addr[5:2]] <= wr_word[15:0];
      if (aw_addr[11:6] == OFS_EVSEL[11:6])
        evsel[aw_addr[5:2]] <= wr_word[4:0];
      if (aw_addr[11:6] == OFS_PATTERN[11:6])
        pattern[aw_addr[5:2]] <= wr_word[15:0];
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  logic [11:0] rd_rel;
  logic [6:0] rd_pool_off;
  logic [31:0] rd_word;
  logic rd_hit;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_rel = s_axi_araddr - OFS_POOL;
    rd_pool_off = rd_rel[8:2] - base_index;
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == OFS_CTRL)
      rd_word = {26'h0000000, ctrl};
    else if (s_axi_araddr == OFS_STATUS)
      rd_word = {25'h0000000, current_step_word, state == ST_COMPLETE, completion_flag};
    else if (s_axi_araddr == OFS_TIMEBASE)
      rd_word = {16'h0000, timebase};
    else if (s_axi_araddr == OFS_BASE_INDEX)
      rd_word = {25'h0000000, base_index};
    else if (s_axi_araddr[11:6] == OFS_COUNTS[11:6])
      rd_word = {16'h0000, counts[s_axi_araddr[5:2]]};
    else if (s_axi_araddr[11:6] == OFS_EVSEL[11:6])
      rd_word = {27'h0000000, evsel[s_axi_araddr[5:2]]};
    else if (s_axi_araddr[11:6] == OFS_PATTERN[11:6])
      rd_word = {16'h0000, pattern[s_axi_araddr[5:2]]};
    else if (s_axi_araddr >= OFS_POOL && s_axi_araddr < OFS_POOL + POOL_SPAN)
    begin
      case (rd_pool_off)
        WORD_STEP_COUNT: rd_word = {16'h0000, step_count_word};
        WORD_TICK_TIMER: rd_word = {16'h0000, tick_timer_word};
        WORD_PRESET: rd_word = {27'h0000000, preset_step_word};
        WORD_CURRENT: rd_word = {27'h0000000, current_step_word};
        default: rd_word = 32'h0000_0000;
      endcase
    end
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // hundredth-second time base, gathered between scans
  // ****************************************************************
  hundredth_tick #(
    .DIVIDE(TICK_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .tick_o(tick)
  );

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pending <= 16'h0000;
    else if (scan_i)
      pending <= {15'h0000, tick}; // a tick in the scan cycle is kept
    else if (tick && pending != 16'hFFFF)
      pending <= pending + 16'h0001;
  end

  // ****************************************************************
  // step evaluation
  // ****************************************************************
  logic [3:0] cur_idx;
  logic [4:0] last_step;
  logic at_last;
  logic run_rise;
  logic jog_rise;
  logic ev_true;
  logic [16:0] timer_sum;
  logic [15:0] eff_base;
  logic [15:0] count_inc;

  always_comb
  begin
    last_step = 5'(STEP_NUM);
    for (int s = 0; s < STEP_NUM; s++)
    begin
      if (counts[s] != 16'h0000 || evsel[s].enable)
        last_step = 5'(s + 1);
    end
  end

  assign cur_idx = 4'(current_step_word - 5'h01);
  assign at_last = current_step_word >= last_step;
  assign run_rise = ctrl.run && !run_q;
  assign jog_rise = ctrl.jog && !jog_q && ctrl.event_variant;
  assign ev_true = !evsel[cur_idx].enable || event_points_i[evsel[cur_idx].point];
  assign eff_base = (timebase == 16'h0000) ? 16'h0001 : timebase;
  assign timer_sum = {1'b0, tick_timer_word} + {1'b0, pending};
  assign count_inc = step_count_word + 16'h0001;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      run_q <= 1'b0;
      jog_q <= 1'b0;
      state <= ST_PROGRAM;
      completion_flag <= 1'b0;
      step_count_word <= 16'h0000;
      tick_timer_word <= 16'h0000;
      current_step_word <= PRESET_RESET;
    end
    else if (scan_i)
    begin
      run_q <= ctrl.run;
      jog_q <= ctrl.jog;
      if (!ctrl.run)
        state <= ST_PROGRAM;
      else if (ctrl.reset || run_rise)
      begin
        state <= ST_ACTIVE;
        completion_flag <= 1'b0;
        if (ctrl.reset || ctrl.non_retentive || completion_flag)
        begin
          current_step_word <= preset_step_word;
          step_count_word <= 16'h0000;
          tick_timer_word <= 16'h0000;
        end
      end
      else if (state == ST_ACTIVE)
      begin
        if (jog_rise)
        begin
          step_count_word <= 16'h0000;
          tick_timer_word <= 16'h0000;
          if (at_last)
          begin
            completion_flag <= 1'b1;
            state <= ST_COMPLETE;
          end
          else
            current_step_word <= current_step_word + 5'h01;
        end
        else if (ctrl.start && ev_true)
        begin
          if (counts[cur_idx] == 16'h0000 || (timer_sum >= {1'b0, eff_base}
              && count_inc >= counts[cur_idx]))
          begin
            if (at_last)
            begin
              completion_flag <= 1'b1;
              state <= ST_COMPLETE;
            end
            else
            begin
              current_step_word <= current_step_word + 5'h01;
              step_count_word <= 16'h0000;
              tick_timer_word <= 16'h0000;
            end
          end
          else if (timer_sum >= {1'b0, eff_base})
          begin
            step_count_word <= count_inc;
            tick_timer_word <= 16'(timer_sum - {1'b0, eff_base});
          end
          else
            tick_timer_word <= timer_sum[15:0];
        end
      end
    end
  end

  // preset word, software writable through its pool slot
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      preset_step_word <= PRESET_RESET;
    else if (wr_go && aw_addr >= OFS_POOL && aw_addr < OFS_POOL + POOL_SPAN
             && wr_pool_off == WORD_PRESET)
    begin
      if (wr_word[4:0] != 5'h00 && wr_word[4:0] <= 5'(STEP_NUM))
        preset_step_word <= wr_word[4:0];
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pattern_o <= 16'h0000;
    else if (run_q)
      pattern_o <= pattern[cur_idx];
    else
      pattern_o <= 16'h0000;
  end

  assign complete_o = completion_flag;

endmodule : step_sequencer
`default_nettype wire

// ### tb/control_program.sv
// scan strobe and event source of the control program
`timescale 1ns/1ns
`default_nettype none
module control_program #(
  parameter int unsigned SCAN_GAP = 8
)(
  input wire logic clk_sys_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic [15:0] ev_level_i, // wanted events
  output logic scan_o, // scan strobe
  output logic [15:0] points_o // event points
);
  int unsigned gap;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gap <= 0;
      scan_o <= 1'b0;
      points_o <= 16'h0000;
    end
    else
    begin
      gap <= (gap == SCAN_GAP - 1) ? 0 : gap + 1;
      scan_o <= (gap == SCAN_GAP - 1);
      points_o <= ev_level_i;
    end
  end
endmodule : control_program
`default_nettype wire

// ### tb/step_sequencer_asserts.sv
// port checker of the step sequencer
`timescale 1ns/1ns
`default_nettype none
module step_sequencer_asserts
  import step_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = HUNDREDTH_CYCLES
)(
  input wire logic clk_sys_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic scan_i, // scan
  input wire logic [15:0] pattern_o, // pattern
  input wire logic complete_o, // flag
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [11:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r resp
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ****
  // sequencer
  // ****
  a_pattern_on_scan: assert property ($changed(pattern_o) |-> $past(scan_i) || $past(scan_i, 2))
    else $error("pattern moved without a scan");
  a_flag_set_scan: assert property ($rose(complete_o) |-> $past(scan_i))
    else $error("flag set off scan");
  a_flag_clear_scan: assert property ($fell(complete_o) |-> $past(scan_i))
    else $error("flag cleared off scan");
  // ****
  // register bus
  // ****
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wr_taken |=> wr_answer)
    else $error("write answer late");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_hole_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:8] == 4'h1
    |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0000_0000)
    else $error("hole read not refused");
endmodule : step_sequencer_asserts
bind step_sequencer step_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_sys_i,
  .rst_b_i, .scan_i, .pattern_o, .complete_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ### tb/step_sequencer_tb.sv
// self-checking bench of the step sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      n_errors++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end \
  end
module step_sequencer_tb
  import step_seq_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } row_type;
  localparam row_type ROWS [8] = '{'{OFS_CTRL, 32'h0000_0000, RESP_OKAY},
    '{OFS_STATUS, 32'h0000_0004, RESP_OKAY}, '{OFS_TIMEBASE, 32'h0000_0001, RESP_OKAY},
    '{OFS_BASE_INDEX, 32'h0000_0000, RESP_OKAY}, '{12'h208, 32'h0000_0001, RESP_OKAY},
    '{12'h20C, 32'h0000_0001, RESP_OKAY}, '{12'h010, 32'h0000_0000, RESP_DECERR},
    '{12'h100, 32'h0000_0000, RESP_DECERR}};
  logic clk_sys_i, rst_b_i, scan_i, complete_o;
  logic [15:0] event_points_i, ev_level, pattern_o;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] d;
  int n_errors, n_checks, i;
  step_sequencer #(.TICK_CYCLES(4)) dut_u (.clk_sys_i, .rst_b_i, .scan_i, .event_points_i,
    .pattern_o, .complete_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  control_program #(.SCAN_GAP(8)) prog_u (.clk_sys_i, .rst_b_i, .ev_level_i(ev_level),
    .scan_o(scan_i), .points_o(event_points_i));
  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic tmo();
    n_errors++;
    stop_test();
  endtask : tmo
  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [1:0] er);
    logic ga, gw, gb;
    logic [1:0] br;
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(negedge clk_sys_i);
      ga = s_axi_awready && s_axi_awvalid;
      gw = s_axi_wready && s_axi_wvalid;
      gb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge clk_sys_i);
      if (ga)
        s_axi_awvalid <= 1'b0;
      if (gw)
        s_axi_wvalid <= 1'b0;
      if (gb)
        break;
    end
    if (k == 40)
      tmo();
    `CHK("bresp", er, br)
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] rd_d, output logic [1:0] rd_r);
    logic g, v;
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(negedge clk_sys_i);
      g = s_axi_arready && s_axi_arvalid;
      v = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge clk_sys_i);
      if (g)
        s_axi_arvalid <= 1'b0;
      if (v)
        break;
    end
    if (k == 40)
      tmo();
  endtask : rd
  task automatic wait_st(input logic [31:0] ex);
    int k;
    for (k = 0; k < 60; k++)
    begin
      rd(OFS_STATUS, d, r);
      if (d === ex)
        break;
    end
    `CHK("status", ex, d)
  endtask : wait_st
  task automatic hold_st(input logic [31:0] ex);
    repeat (64) @(posedge clk_sys_i);
    rd(OFS_STATUS, d, r);
    `CHK("held status", ex, d)
  endtask : hold_st
  task automatic wait_pat(input logic [15:0] ex);
    int k;
    for (k = 0; k < 200; k++)
    begin
      @(negedge clk_sys_i);
      if (pattern_o === ex)
        break;
    end
    `CHK("pattern", ex, pattern_o)
  endtask : wait_pat
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    tmo();
  end
  initial
  begin
    n_errors = 0;
    n_checks = 0;
    rst_b_i = 1'b0;
    ev_level = 16'h0000;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    `CHK("reset pattern", 16'h0000, pattern_o)
    `CHK("reset flag", 1'b0, complete_o)
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    for (i = 0; i < 8; i++)
    begin
      rd(ROWS[i].a, d, r);
      `CHK("register", {ROWS[i].d, ROWS[i].r}, {d, r})
    end
    wr(OFS_COUNTS, 32'h0000_0002, RESP_OKAY);
    wr(OFS_COUNTS + 12'h004, 32'h0000_0001, RESP_OKAY);
    wr(OFS_COUNTS + 12'h008, 32'h0000_0001, RESP_OKAY);
    wr(OFS_EVSEL + 12'h004, 32'h0000_0015, RESP_OKAY);
    wr(OFS_PATTERN, 32'h0000_1111, RESP_OKAY);
    wr(OFS_PATTERN + 12'h004, 32'h0000_2222, RESP_OKAY);
    wr(OFS_PATTERN + 12'h008, 32'h0000_4444, RESP_OKAY);
    wr(12'h010, 32'hFFFF_FFFF, RESP_DECERR);
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    wait_pat(16'h1111);
    hold_st(32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    wait_st(32'h0000_0008);
    hold_st(32'h0000_0008);
    ev_level <= 16'h0020;
    wait_st(32'h0000_000F);
    wait_pat(16'h4444);
    wr(OFS_CTRL, 32'h0000_0027, RESP_OKAY);
    hold_st(32'h0000_000F);
    wr(OFS_CTRL, 32'h0000_002B, RESP_OKAY);
    wait_st(32'h0000_0004);
    `CHK("flag", 1'b0, complete_o)
    hold_st(32'h0000_0004);
    wr(12'h208, 32'h0000_0002, RESP_OKAY);
    wait_st(32'h0000_0008);
    wait_pat(16'h2222);
    wr(OFS_CTRL, 32'h0000_0021, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0025, RESP_OKAY);
    wait_st(32'h0000_000C);
    wr(OFS_CTRL, 32'h0000_0020, RESP_OKAY);
    wait_pat(16'h0000);
    wr(OFS_CTRL, 32'h0000_0021, RESP_OKAY);
    repeat (16) @(posedge clk_sys_i);
    rd(OFS_STATUS, d, r);
    `CHK("retained step", 32'h0000_000C, d)
    wr(OFS_CTRL, 32'h0000_0025, RESP_OKAY);
    wait_st(32'h0000_000F);
    `CHK("flag", 1'b1, complete_o)
    wr(OFS_CTRL, 32'h0000_0030, RESP_OKAY);
    repeat (16) @(posedge clk_sys_i);
    wr(OFS_CTRL, 32'h0000_0031, RESP_OKAY);
    wait_st(32'h0000_0008);
    wr(OFS_CTRL, 32'h0000_0035, RESP_OKAY);
    wait_st(32'h0000_000C);
    wr(OFS_CTRL, 32'h0000_0030, RESP_OKAY);
    repeat (16) @(posedge clk_sys_i);
    wr(OFS_CTRL, 32'h0000_0031, RESP_OKAY);
    wait_st(32'h0000_0008);
    rd(OFS_POOL, d, r);
    `CHK("step count", 32'h0000_0000, d)
    wr(OFS_BASE_INDEX, 32'h0000_0010, RESP_OKAY);
    rd(12'h24C, d, r);
    `CHK("moved current", 32'h0000_0002, d)
    stop_test();
  end
endmodule : step_sequencer_tb
`default_nettype wire
